// *** rtl/irq_prio_regs.svh ***
// Register offsets, field positions and reset values of the interrupt priority block
`ifndef IRQ_PRIO_REGS_SVH
`define IRQ_PRIO_REGS_SVH
// Offsets are word indices; the bus byte address is four times the index
`define OFF_ENABLE_MAIN 8'hA8
`define OFF_LEVEL_UPPER 8'hB7
`define OFF_LEVEL_LOWER 8'hB8
`define OFF_BIT_ACCESS 8'hC0
`define OFF_IRQ_STATUS 8'hC4
`define OFF_IRQ_CLEAR 8'hC8
`define OFF_IRQ_ENABLE 8'hCC
`define OFF_CORE_STATE 8'hD0
`define BIT_GLOBAL_EN 7
`define NUM_SRC 7
`define RESET_ENABLE 8'h00
`define RESET_LEVEL 8'h00
`define SEL_ENABLE 2'h0
`define SEL_LOWER 2'h1
`endif

// *** rtl/irq_prio_pkg.sv ***
// Types shared by the interrupt priority block
package irq_prio_pkg;
  typedef enum logic [1:0]
  {
    AXI_IDLE = 2'b00,
    AXI_RESP = 2'b01
  } axi_state_type;

  typedef struct packed
  {
    axi_state_type wrState;
    axi_state_type rdState;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic awReady;
    logic wReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [7:0] enableMain;
    logic [7:0] levelUpper;
    logic [7:0] levelLower;
    logic [6:0] pendSync1;
    logic [6:0] pendSync2;
    logic [3:0] inService;
    logic irqReq;
    logic [2:0] irqId;
    logic [1:0] irqLevel;
    logic [1:0] evtStatus;
    logic [1:0] evtEnable;
    logic irqOut;
  } state_type;
endpackage

// *** rtl/interrupt_priority_enable.sv ***
// Interrupt enable and four-level priority controller with AXI4-Lite registers
// Notes on behaviour
// - Higher level preempts a running lower routine; equal or lower waits.
// - A level 3 routine is never preempted by anything.
// - Level is upper bit then lower bit; 00 lowest, 11 highest.
// - Simultaneous requests: the higher level is served first.
// - Same level: a fixed polling order picks the winner.
// - Enable bit 7 is global; zero blocks all, one defers to source bits.
// - Enables: counter array 6, timer2 5, serial 4, timer1 3, timer0 1.
// - External 1 enable at bit 2, external 0 enable at bit 0.
// - Enable register resets to zero and accepts single-bit writes.
// - Lower level register at B8h, sources at bits 6 down to 0.
// - Upper level register at B7h, same bit positions as lower.
// - Bit 7 of both level registers reserved; software writes zero.
// - Lower register resets bits 6..0 to zero; bit-addressable.
// - Upper register resets bits 6..0 to zero; whole-byte access only.
// - Full system has nine vectors; this block serves the seven main ones.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "irq_prio_regs.svh"

module interrupt_priority_enable
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [6:0] srcPending,
  input wire logic irqAck,
  input wire logic irqReturn,
  output logic coreIrqReq,
  output logic [2:0] coreIrqId,
  output logic [1:0] coreIrqLevel,
  output logic irqLine,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  irq_prio_pkg::state_type st;
  irq_prio_pkg::state_type next_st;

  // Per-source level and qualified request
  logic [1:0] srcLevel [0:6];
  logic [6:0] srcActive;

  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g = g + 1)
    begin : gen_src
      assign srcLevel[g] = {st.levelUpper[g], st.levelLower[g]};
      assign srcActive[g] = st.pendSync2[g] & st.enableMain[g]
        & st.enableMain[`BIT_GLOBAL_EN];
    end
  endgenerate

  // Arbitration over levels, then polling order
  logic winFound;
  logic [2:0] winId;
  logic [1:0] winLevel;
  logic [1:0] curLevel;
  logic anyService;
  logic allowed;

  always_comb
  begin
    winFound = 1'b0;
    winId = 3'h0;
    winLevel = 2'h0;
    for (int lv = 3; lv >= 0; lv--)
    begin
      for (int s = 0; s < `NUM_SRC; s++)
      begin
        if (!winFound && srcActive[s] && srcLevel[s] == 2'(lv))
        begin
          winFound = 1'b1;
          winId = 3'(s);
          winLevel = 2'(lv);
        end
      end
    end
  end

  always_comb
  begin
    curLevel = 2'h0;
    anyService = |st.inService;
    for (int lv = 0; lv < 4; lv++)
    begin
      if (st.inService[lv])
      begin
        curLevel = 2'(lv);
      end
    end
    // Strictly higher only; level 3 can never be exceeded
    allowed = winFound && (!anyService || winLevel > curLevel);
  end

  // Word index decode; byte lanes and upper address bits are ignored
  logic [7:0] rdIndex;
  logic [31:0] rdWord;
  logic rdMapped;
  logic wrMapped;

  assign rdIndex = s_axi_araddr[9:2];

  // Read mux; unmapped words answer zero with an error response
  always_comb
  begin
    rdWord = 32'h00000000;
    rdMapped = 1'b1;
    case (rdIndex)
      `OFF_ENABLE_MAIN:
        rdWord = {24'h000000, st.enableMain};
      `OFF_LEVEL_UPPER:
        rdWord = {24'h000000, st.levelUpper};
      `OFF_LEVEL_LOWER:
        rdWord = {24'h000000, st.levelLower};
      `OFF_IRQ_STATUS:
        rdWord = {30'h0000000, st.evtStatus};
      `OFF_IRQ_ENABLE:
        rdWord = {30'h0000000, st.evtEnable};
      `OFF_CORE_STATE:
        rdWord = {21'h00000, st.inService, 1'b0, st.irqLevel, st.irqId, st.irqReq};
      // Write-only registers read as zero
      `OFF_BIT_ACCESS, `OFF_IRQ_CLEAR:
        rdWord = 32'h00000000;
      default:
        rdMapped = 1'b0;
    endcase
  end

  // Status and core state take writes but ignore them
  always_comb
  begin
    case (st.awAddr)
      `OFF_ENABLE_MAIN, `OFF_LEVEL_UPPER, `OFF_LEVEL_LOWER, `OFF_BIT_ACCESS,
      `OFF_IRQ_CLEAR, `OFF_IRQ_ENABLE, `OFF_IRQ_STATUS, `OFF_CORE_STATE:
        wrMapped = 1'b1;
      default:
        wrMapped = 1'b0;
    endcase
  end

  // Register write helper with byte-lane and bit-access handling
  logic wrFire;
  logic [7:0] wrByte;

  always_comb
  begin
    next_st = st;
    wrFire = 1'b0;
    wrByte = st.wData[7:0];

    // Pending inputs come from other logic domains
    next_st.pendSync1 = srcPending;
    next_st.pendSync2 = st.pendSync1;

    // Write address and data, either order
    if (st.awReady && s_axi_awvalid)
    begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr[9:2];
      next_st.awReady = 1'b0;
    end
    if (st.wReady && s_axi_wvalid)
    begin
      next_st.wHeld = 1'b1;
      next_st.wData = {s_axi_wdata[31:1], s_axi_wdata[0]};
      next_st.wData[3:0] = s_axi_wdata[3:0];
      next_st.wReady = 1'b0;
      // Lane 0 strobe rides in the unused top data bit
      next_st.wData[31] = s_axi_wstrb[0];
    end

    case (st.wrState)
      irq_prio_pkg::AXI_IDLE:
      begin
        if (st.awHeld && st.wHeld)
        begin
          wrFire = st.wData[31];
          next_st.awHeld = 1'b0;
          next_st.wHeld = 1'b0;
          next_st.bValid = 1'b1;
          next_st.bResp = wrMapped ? 2'b00 : 2'b10;
          next_st.wrState = irq_prio_pkg::AXI_RESP;
        end
      end
      irq_prio_pkg::AXI_RESP:
      begin
        if (s_axi_bready)
        begin
          next_st.bValid = 1'b0;
          next_st.awReady = 1'b1;
          next_st.wReady = 1'b1;
          next_st.wrState = irq_prio_pkg::AXI_IDLE;
        end
      end
      default:
        next_st.wrState = irq_prio_pkg::AXI_IDLE;
    endcase

    if (wrFire)
    begin
      case (st.awAddr)
        `OFF_ENABLE_MAIN:
          next_st.enableMain = wrByte;
        `OFF_LEVEL_UPPER:
          next_st.levelUpper = {1'b0, wrByte[6:0]};
        `OFF_LEVEL_LOWER:
          next_st.levelLower = {1'b0, wrByte[6:0]};
        `OFF_BIT_ACCESS:
        begin
          // Bits [4:2] select bit, [1:0] register, bit 7 the value
          if (st.wData[1:0] == `SEL_ENABLE)
          begin
            next_st.enableMain[st.wData[4:2]] = st.wData[7];
          end
          else if (st.wData[1:0] == `SEL_LOWER && st.wData[4:2] != 3'h7)
          begin
            next_st.levelLower[st.wData[4:2]] = st.wData[7];
          end
        end
        `OFF_IRQ_ENABLE:
          next_st.evtEnable = wrByte[1:0];
        default:
          next_st.evtEnable = next_st.evtEnable;
      endcase
    end

    // Read channel
    case (st.rdState)
      irq_prio_pkg::AXI_IDLE:
      begin
        if (st.arReady && s_axi_arvalid)
        begin
          next_st.arReady = 1'b0;
          next_st.rValid = 1'b1;
          next_st.rData = rdWord;
          next_st.rResp = rdMapped ? 2'b00 : 2'b10;
          next_st.rdState = irq_prio_pkg::AXI_RESP;
        end
      end
      irq_prio_pkg::AXI_RESP:
      begin
        if (s_axi_rready)
        begin
          next_st.rValid = 1'b0;
          next_st.arReady = 1'b1;
          next_st.rdState = irq_prio_pkg::AXI_IDLE;
        end
      end
      default:
        next_st.rdState = irq_prio_pkg::AXI_IDLE;
    endcase

    // Request to core; id and level follow the winner
    next_st.irqReq = allowed;
    next_st.irqId = winId;
    next_st.irqLevel = winLevel;

    // Service record: return clears the top level first, then entry sets
    if (irqReturn)
    begin
      for (int lv = 3; lv >= 0; lv--)
      begin
        if (st.inService[lv] && 2'(lv) == curLevel)
        begin
          next_st.inService[lv] = 1'b0;
        end
      end
    end
    if (irqAck && st.irqReq)
    begin
      next_st.inService[st.irqLevel] = 1'b1;
    end

    // Events: 0 = request accepted, 1 = routine returned; set beats clear
    if (wrFire && st.awAddr == `OFF_IRQ_CLEAR)
    begin
      next_st.evtStatus = st.evtStatus & ~wrByte[1:0];
    end
    if (irqAck && st.irqReq)
    begin
      next_st.evtStatus[0] = 1'b1;
    end
    if (irqReturn && anyService)
    begin
      next_st.evtStatus[1] = 1'b1;
    end
    next_st.irqOut = |(st.evtStatus & st.evtEnable);
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.awReady <= 1'b1;
      st.wReady <= 1'b1;
      st.arReady <= 1'b1;
      st.enableMain <= `RESET_ENABLE;
      st.levelUpper <= `RESET_LEVEL;
      st.levelLower <= `RESET_LEVEL;
    end
    else if (clkEn)
    begin
      st <= next_st;
    end
  end

  assign coreIrqReq = st.irqReq;
  assign coreIrqId = st.irqId;
  assign coreIrqLevel = st.irqLevel;
  assign irqLine = st.irqOut;
  assign s_axi_awready = st.awReady;
  assign s_axi_wready = st.wReady;
  assign s_axi_bresp = st.bResp;
  assign s_axi_bvalid = st.bValid;
  assign s_axi_arready = st.arReady;
  assign s_axi_rdata = st.rData;
  assign s_axi_rresp = st.rResp;
  assign s_axi_rvalid = st.rValid;

endmodule

// *** tb/irq_prio_props.sv ***
// Checker of core request and register handshake timing
`timescale 1ns/1ps
module irq_prio_props
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [6:0] srcPending,
  input wire logic irqAck,
  input wire logic irqReturn,
  input wire logic coreIrqReq,
  input wire logic [2:0] coreIrqId,
  input wire logic [1:0] coreIrqLevel,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Two sync flops plus the request register
  property p_req_src;
    coreIrqReq |-> |($past(srcPending, 3) & (7'h01 << coreIrqId));
  endproperty
  a_req_src: assert property (p_req_src) else $error("request without source");
  property p_ack_drop;
    irqAck && coreIrqReq |-> ##2 (!coreIrqReq || coreIrqLevel > $past(coreIrqLevel, 2));
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("equal level not held off");
  property p_lvl3;
    (irqAck && coreIrqReq && coreIrqLevel == 2'h3) |->
      ((##2 (!coreIrqReq) [*4]) or (##[0:5] irqReturn));
  endproperty
  a_lvl3: assert property (p_lvl3) else $error("top level routine preempted");
  property p_aw_drop;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_drop: assert property (p_aw_drop) else $error("awready stayed high");
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write response late");
  property p_b_pulse;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_pulse: assert property (p_b_pulse) else $error("bvalid stayed high");
  property p_r_next;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_next: assert property (p_r_next) else $error("read data late");
  property p_r_one;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_r_one: assert property (p_r_one) else $error("read not closed");
  c_ack: cover property (irqAck && coreIrqReq);
  c_top: cover property (coreIrqReq && coreIrqLevel == 2'h3);
  c_ret: cover property (irqReturn);
endmodule

// *** tb/irq_core_model.sv ***
// Behavioural core that accepts requests and returns from routines
`timescale 1ns/1ps
module irq_core_model
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic coreIrqReq,
  input wire logic ackOn,
  input wire logic retReq,
  output logic irqAck,
  output logic irqReturn
);
  logic [1:0] cool;
  // Cooldown avoids a second accept while the taken request drops
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      irqAck <= 1'h0;
      irqReturn <= 1'h0;
      cool <= 2'h0;
    end
    else
    begin
      irqAck <= coreIrqReq && ackOn && cool == 2'h0 && !irqAck;
      irqReturn <= retReq;
      cool <= irqAck ? 2'h3 : (cool == 2'h0 ? 2'h0 : cool - 2'h1);
    end
  end
endmodule

// *** tb/testbench.sv ***
// Testbench for the interrupt priority controller
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'h0, sys_rst = 1'h1, clkEn = 1'h1, ackOn = 1'h0, retReq = 1'h0;
  logic [6:0] srcPending = 7'h00;
  logic irqAck, irqReturn, coreIrqReq, irqLine;
  logic [2:0] coreIrqId;
  logic [1:0] coreIrqLevel, s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int error_cnt = 0, compares = 0, cyc = 0;
  always #2.5 mclk = ~mclk;
  interrupt_priority_enable u_interrupt_priority_enable (.mclk, .sys_rst, .clkEn,
    .srcPending, .irqAck, .irqReturn, .coreIrqReq, .coreIrqId, .coreIrqLevel, .irqLine,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  irq_core_model u_irq_core_model (.mclk, .sys_rst, .coreIrqReq, .ackOn, .retReq,
    .irqAck, .irqReturn);
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    // Word index times four gives the byte address
    s_axi_awaddr <= {22'h0, a, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= {22'h0, a, 2'h0};
    s_axi_arvalid <= 1'h1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  task automatic expReq(input logic [2:0] id, input logic [1:0] lv);
    repeat (4) @(posedge mclk);
    chk("req", 1, coreIrqReq);
    chk("id", id, coreIrqId);
    chk("level", lv, coreIrqLevel);
  endtask
  task automatic noReq;
    repeat (6)
    begin
      @(posedge mclk);
      chk("idle", 0, coreIrqReq);
    end
  endtask
  task automatic waitAck;
    while (irqAck !== 1'h1)
      @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_regs;
    rd(8'hA8, 8'h00, 2'h0);
    rd(8'hB7, 8'h00, 2'h0);
    rd(8'hB8, 8'h00, 2'h0);
    wr(8'hB7, 8'h7F, 2'h0);
    rd(8'hB7, 8'h7F, 2'h0);
    wr(8'hB8, 8'h55, 2'h0);
    rd(8'hB8, 8'h55, 2'h0);
    wr(8'hA8, 8'hFF, 2'h0);
    wr(8'hC0, 8'h0C, 2'h0);
    rd(8'hA8, 8'hF7, 2'h0);
    s_axi_wstrb <= 4'hE;
    wr(8'hA8, 8'h00, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'hA8, 8'hF7, 2'h0);
    wr(8'hC0, 8'h85, 2'h0);
    rd(8'hB8, 8'h57, 2'h0);
    wr(8'h04, 8'h01, 2'h2);
    rd(8'h04, 8'h00, 2'h2);
    $display("Test registers done");
  endtask
  task automatic t_sel;
    wr(8'hB7, 8'h00, 2'h0);
    wr(8'hB8, 8'h00, 2'h0);
    wr(8'hA8, 8'h7F, 2'h0);
    srcPending <= 7'h02;
    noReq();
    wr(8'hA8, 8'h82, 2'h0);
    expReq(3'h1, 2'h0);
    srcPending <= 7'h7F;
    for (int i = 0; i < 7; i++)
    begin
      wr(8'hA8, 8'h80 | (8'h01 << i), 2'h0);
      expReq(i[2:0], 2'h0);
    end
    wr(8'hA8, 8'hFF, 2'h0);
    srcPending <= 7'h41;
    wr(8'hB7, 8'h40, 2'h0);
    wr(8'hB8, 8'h01, 2'h0);
    expReq(3'h6, 2'h2);
    wr(8'hB7, 8'h41, 2'h0);
    expReq(3'h0, 2'h3);
    wr(8'hB7, 8'h00, 2'h0);
    wr(8'hB8, 8'h00, 2'h0);
    srcPending <= 7'h7E;
    expReq(3'h1, 2'h0);
    srcPending <= 7'h00;
    repeat (4) @(posedge mclk);
    clkEn <= 1'h0;
    srcPending <= 7'h02;
    noReq();
    clkEn <= 1'h1;
    expReq(3'h1, 2'h0);
    $display("Test selection done");
  endtask
  task automatic t_nest;
    srcPending <= 7'h00;
    wr(8'hB8, 8'h0A, 2'h0);
    wr(8'hB7, 8'h28, 2'h0);
    wr(8'hCC, 8'h01, 2'h0);
    ackOn <= 1'h1;
    srcPending <= 7'h02;
    waitAck();
    noReq();
    chk("line", 1, irqLine);
    rd(8'hC4, 8'h01, 2'h0);
    wr(8'hCC, 8'h00, 2'h0);
    repeat (2) @(posedge mclk);
    chk("line", 0, irqLine);
    wr(8'hC8, 8'h01, 2'h0);
    rd(8'hC4, 8'h00, 2'h0);
    ackOn <= 1'h0;
    srcPending <= 7'h2A;
    expReq(3'h3, 2'h3);
    ackOn <= 1'h1;
    waitAck();
    ackOn <= 1'h0;
    noReq();
    rd(8'hD0, 32'h00000536, 2'h0);
    srcPending <= 7'h22;
    retReq <= 1'h1;
    @(posedge mclk);
    retReq <= 1'h0;
    expReq(3'h5, 2'h2);
    rd(8'hC4, 8'h03, 2'h0);
    $display("Test nesting done");
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'h0;
    @(posedge mclk);
    t_regs();
    t_sel();
    t_nest();
    complete_run();
  end
endmodule
bind interrupt_priority_enable irq_prio_props u_irq_prio_props (.mclk, .sys_rst, .srcPending,
  .irqAck, .irqReturn, .coreIrqReq, .coreIrqId, .coreIrqLevel, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
